// File: pkg/wrc_pkg.sv
// Constants for the watchdog and chip reset controller.
// Assumes a 32-bit classic Wishbone slave and synchronous pin inputs.
package wrc_pkg;

  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;

  // Register byte addresses
  localparam logic [7:0] WATCHDOG_CONTROL_ADR = 8'h00;
  localparam logic [7:0] VERSION_STATUS_ADR = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADR = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_ADR = 8'h0c;
  localparam logic [7:0] IRQ_ENABLE_ADR = 8'h10;

  // Watchdog control fields
  localparam int unsigned WD_ENABLE_BIT = 0;
  localparam int unsigned SVC_ONE_BIT = 1;
  localparam int unsigned SVC_TWO_BIT = 2;
  localparam int unsigned SVC_ARMED_BIT = 3;

  // Version and status fields
  localparam int unsigned SOFT_RESET_OUT_BIT = 0;
  localparam int unsigned IND_ACTIVE_BIT = 4;
  localparam int unsigned CHIP_RESET_BIT = 5;

  // Interrupt fields
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_WD_OVERFLOW = 0;
  localparam int unsigned IRQ_IND_DONE = 1;

  // Timing in frame sync and data clock periods
  localparam int unsigned WD_PERIOD_FRAMES = 1024;
  localparam int unsigned RESET_FRAMES = 8;
  localparam int unsigned SVC_GAP_DCLK = 2;
  localparam logic [10:0] WD_LAST = 11'(WD_PERIOD_FRAMES - 1);
  localparam logic [3:0] RESET_LAST = 4'(RESET_FRAMES - 1);
  localparam logic [1:0] SVC_GAP = 2'(SVC_GAP_DCLK);

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    WRC_SVC_IDLE = 2'b00,
    WRC_SVC_ARMED = 2'b01
  } wrc_svc_e;

endpackage

// File: src/wrc_top.sv
// Watchdog timer and chip reset control with a Wishbone register slave.
// Assumes frame sync, data clock and external reset are synchronous to i_clk.
//
// Summary of operation
// - Watchdog is off after reset; software enable bit turns it on.
// - Software cannot turn the watchdog off; only a chip reset does.
// - Watchdog period is 1024 frame sync cycles with data clock running.
// - Missed service raises overflow interrupt and reset indication, state kept.
// - After power-up the block sits in resetting state, refusing bus access.
// - Power-up resetting ends after eight qualified frame sync periods.
// - External reset overrides power-on reset and can end it early.
// - During reset other outputs float; exempt outputs keep driving.
// - PCM tristate controls are driven high during chip reset.
// - Reset indication on power-up, external reset and watchdog expiry.
// - Internal causes hold indication eight frames; external follows pulse width.
// - Indication starts at once on external reset; ends at next data clock rise.
// - Soft reset-out bit drives indication without resetting the block.
// - Only power-up and external reset reset the block internally.
`timescale 1ns/1ps
`default_nettype none

module wrc_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_frame_sync_in,
  input wire logic i_data_clock_in,
  input wire logic i_external_reset_in_n,
  input wire logic [1:0] i_pcm_tristate_ctrl,
  output logic [1:0] o_pcm_tristate_ctrl,
  output logic o_reset_indication_out_n,
  output logic o_outputs_oe_n,
  output logic o_chip_reset,
  output logic o_watchdog_overflow_irq,
  output logic o_irq
);

  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_sync_n_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  wire logic rst_n = rst_sync_n_reg;

  // Edge detection of the sampled line clocks
  logic fs_prev_reg;
  logic dc_prev_reg;
  logic dc_seen_reg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_prev_reg <= 1'b0;
      dc_prev_reg <= 1'b0;
    end else begin
      fs_prev_reg <= i_frame_sync_in;
      dc_prev_reg <= i_data_clock_in;
    end
  end

  wire logic fs_rise = i_frame_sync_in & ~fs_prev_reg;
  wire logic dc_rise = i_data_clock_in & ~dc_prev_reg;

  // A frame only counts when the data clock ticked within it
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      dc_seen_reg <= 1'b0;
    end else if (fs_rise) begin
      dc_seen_reg <= dc_rise;
    end else if (dc_rise) begin
      dc_seen_reg <= 1'b1;
    end
  end

  wire logic frame_tick = fs_rise & dc_seen_reg;

  // External reset and its release at a data clock edge
  wire logic ext_act = ~i_external_reset_in_n;
  logic ext_hold_reg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_hold_reg <= 1'b0;
    end else if (ext_act) begin
      ext_hold_reg <= 1'b1;
    end else if (dc_rise) begin
      ext_hold_reg <= 1'b0;
    end
  end

  // Power-up resetting state
  logic pwr_reset_reg;
  logic [3:0] pwr_cnt_reg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reset_reg <= 1'b1;
      pwr_cnt_reg <= 4'h0;
    end else if (ext_act) begin
      pwr_reset_reg <= 1'b0;
      pwr_cnt_reg <= 4'h0;
    end else if (pwr_reset_reg && frame_tick) begin
      if (pwr_cnt_reg == wrc_pkg::RESET_LAST) begin
        pwr_reset_reg <= 1'b0;
      end
      pwr_cnt_reg <= pwr_cnt_reg + 4'h1;
    end
  end

  // Only power-up and external reset clear internal state
  wire logic chip_reset = pwr_reset_reg | ext_act | ext_hold_reg;

  // Bus slave; stalled while resetting, writes land on the ack edge
  wire logic bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~chip_reset;
  wire logic wr_stb = i_wb_cyc & i_wb_stb & o_wb_ack & ~chip_reset & i_wb_we & i_wb_sel[0];

  // Watchdog control and service sequence
  logic wd_enable_reg;
  wrc_pkg::wrc_svc_e svc_state_reg;
  logic [1:0] svc_gap_reg;
  logic [10:0] wd_cnt_reg;
  logic wd_expire;
  logic svc_done;

  wire logic wr_wdc = wr_stb & (i_wb_adr == wrc_pkg::WATCHDOG_CONTROL_ADR);
  wire logic svc_one = i_wb_dat[wrc_pkg::SVC_ONE_BIT];
  wire logic svc_two = i_wb_dat[wrc_pkg::SVC_TWO_BIT];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_enable_reg <= 1'b0;
    end else if (chip_reset) begin
      wd_enable_reg <= 1'b0;
    end else if (wr_wdc && i_wb_dat[wrc_pkg::WD_ENABLE_BIT]) begin
      wd_enable_reg <= 1'b1;
    end
  end

  // Second write counts only after the gap in data clock periods
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      svc_state_reg <= wrc_pkg::WRC_SVC_IDLE;
      svc_gap_reg <= 2'h0;
    end else if (chip_reset) begin
      svc_state_reg <= wrc_pkg::WRC_SVC_IDLE;
      svc_gap_reg <= 2'h0;
    end else begin
      case (svc_state_reg)
        wrc_pkg::WRC_SVC_IDLE: begin
          if (wr_wdc && svc_one && !svc_two) begin
            svc_state_reg <= wrc_pkg::WRC_SVC_ARMED;
            svc_gap_reg <= 2'h0;
          end
        end
        wrc_pkg::WRC_SVC_ARMED: begin
          if (svc_done || wd_expire) begin
            svc_state_reg <= wrc_pkg::WRC_SVC_IDLE;
          end else if (dc_rise && svc_gap_reg != wrc_pkg::SVC_GAP) begin
            svc_gap_reg <= svc_gap_reg + 2'h1;
          end
        end
        default: begin
          svc_state_reg <= wrc_pkg::WRC_SVC_IDLE;
        end
      endcase
    end
  end

  // Early or unordered second writes are dropped
  assign svc_done = wr_wdc && !svc_one && svc_two
                    && svc_state_reg == wrc_pkg::WRC_SVC_ARMED
                    && svc_gap_reg == wrc_pkg::SVC_GAP;

  assign wd_expire = wd_enable_reg && frame_tick && wd_cnt_reg == wrc_pkg::WD_LAST;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_reg <= 11'h000;
    end else if (chip_reset || !wd_enable_reg || svc_done || wd_expire) begin
      wd_cnt_reg <= 11'h000;
    end else if (frame_tick) begin
      wd_cnt_reg <= wd_cnt_reg + 11'h001;
    end
  end

  // Internally timed indication pulse
  logic [3:0] ind_cnt_reg;
  logic ind_pulse_reg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_pulse_reg <= 1'b0;
      ind_cnt_reg <= 4'h0;
    end else if (ext_act) begin
      ind_pulse_reg <= 1'b0;
      ind_cnt_reg <= 4'h0;
    end else if (wd_expire) begin
      ind_pulse_reg <= 1'b1;
      ind_cnt_reg <= 4'h0;
    end else if (ind_pulse_reg && frame_tick) begin
      if (ind_cnt_reg == wrc_pkg::RESET_LAST) begin
        ind_pulse_reg <= 1'b0;
      end
      ind_cnt_reg <= ind_cnt_reg + 4'h1;
    end
  end

  // Soft reset-out bit
  logic soft_reset_reg;
  wire logic wr_vns = wr_stb & (i_wb_adr == wrc_pkg::VERSION_STATUS_ADR);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_reg <= 1'b0;
    end else if (chip_reset) begin
      soft_reset_reg <= 1'b0;
    end else if (wr_vns) begin
      soft_reset_reg <= i_wb_dat[wrc_pkg::SOFT_RESET_OUT_BIT];
    end
  end

  // Combinational so that external reset shows without delay
  wire logic ind_active = ext_act | ext_hold_reg | pwr_reset_reg
                          | ind_pulse_reg | soft_reset_reg;
  logic ind_prev_reg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_prev_reg <= 1'b1;
    end else begin
      ind_prev_reg <= ind_active;
    end
  end

  // Interrupt status, clear and enable
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic [1:0] irq_set;

  wire logic wr_clr = wr_stb & (i_wb_adr == wrc_pkg::IRQ_CLEAR_ADR);
  wire logic wr_ena = wr_stb & (i_wb_adr == wrc_pkg::IRQ_ENABLE_ADR);

  always_comb begin
    irq_set = 2'h0;
    irq_set[wrc_pkg::IRQ_WD_OVERFLOW] = wd_expire;
    irq_set[wrc_pkg::IRQ_IND_DONE] = ind_prev_reg & ~ind_active;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= 2'h0;
    end else if (chip_reset) begin
      irq_status_reg <= 2'h0;
    end else if (wr_clr) begin
      irq_status_reg <= (irq_status_reg & ~i_wb_dat[1:0]) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_reg <= 2'h0;
    end else if (chip_reset) begin
      irq_enable_reg <= 2'h0;
    end else if (wr_ena) begin
      irq_enable_reg <= i_wb_dat[1:0];
    end
  end

  // Read mux
  logic [31:0] rd_data;

  always_comb begin
    rd_data = wrc_pkg::RD_ZERO;
    case (i_wb_adr)
      wrc_pkg::WATCHDOG_CONTROL_ADR: begin
        rd_data[wrc_pkg::WD_ENABLE_BIT] = wd_enable_reg;
        rd_data[wrc_pkg::SVC_ARMED_BIT] = svc_state_reg == wrc_pkg::WRC_SVC_ARMED;
      end
      wrc_pkg::VERSION_STATUS_ADR: begin
        rd_data[wrc_pkg::SOFT_RESET_OUT_BIT] = soft_reset_reg;
        rd_data[wrc_pkg::IND_ACTIVE_BIT] = ind_active;
        rd_data[wrc_pkg::CHIP_RESET_BIT] = chip_reset;
      end
      wrc_pkg::IRQ_STATUS_ADR: begin
        rd_data[1:0] = irq_status_reg;
      end
      wrc_pkg::IRQ_ENABLE_ADR: begin
        rd_data[1:0] = irq_enable_reg;
      end
      default: begin
        rd_data = wrc_pkg::RD_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= wrc_pkg::RD_ZERO;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_req && !i_wb_we) begin
        o_wb_dat <= rd_data;
      end
    end
  end

  // Pin side
  assign o_reset_indication_out_n = ~ind_active;
  assign o_outputs_oe_n = chip_reset;
  assign o_pcm_tristate_ctrl = chip_reset ? 2'h3 : i_pcm_tristate_ctrl;
  assign o_chip_reset = chip_reset;
  assign o_watchdog_overflow_irq = irq_status_reg[wrc_pkg::IRQ_WD_OVERFLOW];
  assign o_irq = |(irq_status_reg & irq_enable_reg);

endmodule

`default_nettype wire

// File: verif/wrc_assertions.sv
// Port checker for the watchdog and reset controller.
// Bound into wrc_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module wrc_assertions (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_external_reset_in_n,
  input wire logic [1:0] o_pcm_tristate_ctrl,
  input wire logic o_reset_indication_out_n,
  input wire logic o_outputs_oe_n,
  input wire logic o_chip_reset,
  input wire logic o_watchdog_overflow_irq,
  input wire logic o_wb_ack
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_taken;
    i_wb_cyc && i_wb_stb && !o_wb_ack && !o_chip_reset;
  endsequence
  sequence s_ack_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  a_ack_one_cycle: assert property (s_taken |=> s_ack_pulse) else $error("ack not one cycle after request");
  a_no_ack_reset: assert property (o_chip_reset |=> !o_wb_ack) else $error("ack during reset");
  a_ext_ind_now: assert property (!i_external_reset_in_n |-> o_chip_reset && !o_reset_indication_out_n)
    else $error("external reset not immediate");
  a_ind_ext_tail: assert property ($rose(i_external_reset_in_n) |-> !o_reset_indication_out_n)
    else $error("indication released early");
  a_pcm_forced: assert property (o_chip_reset |-> o_pcm_tristate_ctrl == 2'b11) else $error("pcm control not high");
  a_oe_float: assert property (o_outputs_oe_n == o_chip_reset) else $error("output float mismatch");
  a_chip_ind: assert property (o_chip_reset |-> !o_reset_indication_out_n) else $error("reset without indication");
  a_ovf_ind: assert property ($rose(o_watchdog_overflow_irq) |-> ##1 (!o_reset_indication_out_n && !o_chip_reset))
    else $error("overflow without indication");
endmodule
bind wrc_top wrc_assertions u_wrc_assertions (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb),
  .i_external_reset_in_n(i_external_reset_in_n),
  .o_pcm_tristate_ctrl(o_pcm_tristate_ctrl),
  .o_reset_indication_out_n(o_reset_indication_out_n),
  .o_outputs_oe_n(o_outputs_oe_n),
  .o_chip_reset(o_chip_reset),
  .o_watchdog_overflow_irq(o_watchdog_overflow_irq),
  .o_wb_ack(o_wb_ack)
);
`default_nettype wire

// File: verif/wrc_partner.sv
// Board clock source: frame sync and data clock.
// Runs from the bench clock; both lines idle low while stopped.
`timescale 1ns/1ps
`default_nettype none
module wrc_partner (
  input wire logic i_clk,
  input wire logic i_run,
  output logic o_frame_sync,
  output logic o_data_clock
);
  logic [2:0] phase_reg;
  // Eight cycles a frame, two data clock rises in each
  always_ff @(posedge i_clk) begin
    phase_reg <= i_run ? phase_reg + 3'h1 : 3'h0;
    o_frame_sync <= i_run && (phase_reg == 3'h7);
    o_data_clock <= i_run && phase_reg[1];
  end
endmodule
`default_nettype wire

// File: verif/wrc_tb_top.sv
// Self-checking bench for the watchdog and reset controller.
// Partner supplies frame timing; registers over classic Wishbone.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module wrc_tb_top;
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0, ext_n = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [1:0] pcm = 2'h0, pcm_o;
  logic ack, ind_n, oe_n, crst, ovf, irq, fs, dc;
  int n_mismatch = 0, n_compared = 0, frames = 0, seed = 51000, t0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    pcm <= 2'($random(seed));
    if (fs) frames <= frames + 1;
  end
  wrc_partner P (.i_clk(clk), .i_run(run), .o_frame_sync(fs), .o_data_clock(dc));
  wrc_top DUT (.i_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_frame_sync_in(fs), .i_data_clock_in(dc), .i_external_reset_in_n(ext_n),
    .i_pcm_tristate_ctrl(pcm), .o_pcm_tristate_ctrl(pcm_o), .o_reset_indication_out_n(ind_n),
    .o_outputs_oe_n(oe_n), .o_chip_reset(crst), .o_watchdog_overflow_irq(ovf), .o_irq(irq));
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic ext_pulse;
    ext_n <= 1'b0; // four data clock periods
    repeat (16) @(posedge clk);
    @(negedge clk);
    `CHK({crst, oe_n, pcm_o, ind_n}, 5'b11110)
    @(posedge clk);
    ext_n <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK({crst, oe_n, ind_n, pcm_o}, {3'b001, pcm})
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    run <= 1'b0;
    repeat (200) @(posedge clk);
    `CHK({crst, ind_n}, 2'b10)
    run <= 1'b1;
    t0 = frames;
    // Stalls until power-up resetting ends
    wb(1'b0, 8'h00, 32'h0);
    `CHK(frames - t0 inside {[8:9]}, 1'b1)
    `CHK(q[0], 1'b0)
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q[0], 1'b1)
    wb(1'b1, 8'h00, 32'h5);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q[3], 1'b0)
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b1, 8'h00, 32'h5);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q[3], 1'b1)
    repeat (10) @(posedge clk);
    wb(1'b1, 8'h00, 32'h5);
    t0 = frames;
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q[3], 1'b0)
    wb(1'b1, 8'h10, 32'h0);
    wait (ovf === 1'b1);
    @(negedge clk);
    `CHK(frames - t0 inside {[1023:1025]}, 1'b1)
    `CHK({crst, ind_n, irq}, 3'b000)
    t0 = frames;
    wait (ind_n === 1'b1);
    @(negedge clk);
    `CHK(frames - t0 inside {[7:9]}, 1'b1)
    wb(1'b0, 8'h08, 32'h0);
    `CHK(q[1:0], 2'b11)
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q[0], 1'b1)
    wb(1'b1, 8'h10, 32'h1);
    @(negedge clk);
    `CHK(irq, 1'b1)
    wb(1'b1, 8'h0c, 32'h3);
    wb(1'b0, 8'h08, 32'h0);
    `CHK({q[1:0], irq}, 3'b000)
    wb(1'b1, 8'h04, 32'h1);
    @(negedge clk);
    `CHK({crst, ind_n}, 2'b00)
    wb(1'b1, 8'h04, 32'h0);
    @(negedge clk);
    `CHK(ind_n, 1'b1)
    wb(1'b0, 8'h80 | 8'($random(seed)), 32'h0);
    `CHK(q, 32'h0)
    ext_pulse();
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q[0], 1'b0)
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (24) @(posedge clk);
    ext_pulse();
    give_verdict();
  end
endmodule
`default_nettype wire
